// ### verilog/dscp_top.sv
// dual serial control port: 4-wire port or two-wire slave, plus registers
// assumes the testbench resolves the shared data pin from the two enables
`timescale 1ns/10ps
module dscp_top (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic interface_select_pin,
    input wire logic control_select_n,
    input wire logic control_serial_in,
    input wire logic control_bit_clock,
    input wire logic control_serial_out_in,
    output logic control_serial_out,
    output logic control_serial_out_oe,
    output logic sda_oe,
    output dscp_pkg::dscp_regs_t mode_regs
);
    import dscp_pkg::*;

    // -----------------------------------------------------------------
    // state
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic [1:0] sel_s;
        logic [1:0] a0_s;
        logic [1:0] a1_s;
        logic [1:0] done_s;
        logic done_prev;
        logic scl_f;
        logic sda_f;
        logic [3:0] scl_cnt;
        logic [3:0] sda_cnt;
        logic scl_prev;
        logic sda_prev;
        dscp_i2c_state_t st;
        logic [3:0] bitn;
        logic [7:0] sh;
        logic rw;
        logic nack;
        logic [6:0] idx;
        logic [6:0] last_wr;
        logic wrote;
        logic oe;
        dscp_regs_t regs;
    } dscp_top_state_t;

    dscp_top_state_t s;
    dscp_top_state_t next_s;
    logic spi_done;
    dscp_word_t spi_word;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic [4:0] scl_step;
    logic [4:0] sda_step;
    logic [7:0] rbyte;
    logic [6:0] ridx;

    // -----------------------------------------------------------------
    // 4-wire port in its own clock domain
    // -----------------------------------------------------------------
    dscp_spi_port u_spi (
        .control_bit_clock(control_bit_clock),
        .control_select_n(control_select_n),
        .control_serial_in(control_serial_in),
        .interface_select_pin(interface_select_pin),
        .regs(s.regs),
        .word_done(spi_done),
        .word(spi_word),
        .serial_out(control_serial_out),
        .serial_out_oe(control_serial_out_oe)
    );

    // -----------------------------------------------------------------
    // spike filter
    // -----------------------------------------------------------------
    // a new level must hold for the longest suppressed spike before it is
    // taken; at this clock rate the slow-clock failure cases cannot arise
    function automatic logic [4:0] filt_step(logic level, logic [3:0] cnt,
                                             logic raw);
        logic [3:0] inc;
        inc = cnt + 4'h1;
        if (raw == level) begin
            return {level, 4'h0};
        end
        if (inc == SPIKE_CNT) begin
            return {raw, 4'h0};
        end
        return {level, inc};
    endfunction

    assign scl_step = filt_step(s.scl_f, s.scl_cnt, s.scl_s[1]);
    assign sda_step = filt_step(s.sda_f, s.sda_cnt, s.sda_s[1]);

    // -----------------------------------------------------------------
    // bus events
    // -----------------------------------------------------------------
    assign scl_rise = s.scl_f && !s.scl_prev;
    assign scl_fall = !s.scl_f && s.scl_prev;
    assign bus_start = s.scl_f && s.scl_prev && s.sda_prev && !s.sda_f;
    assign bus_stop = s.scl_f && s.scl_prev && !s.sda_prev && s.sda_f;

    // a read entered straight after a data write restarts at that register
    assign ridx = s.wrote ? s.last_wr : s.idx;
    assign rbyte = dscp_rd_lookup(s.regs, s.idx);

    // -----------------------------------------------------------------
    // next state
    // -----------------------------------------------------------------
    always_comb begin
        next_s = s;
        next_s.scl_s = {s.scl_s[0], control_bit_clock};
        next_s.sda_s = {s.sda_s[0], control_serial_out_in};
        next_s.sel_s = {s.sel_s[0], interface_select_pin};
        next_s.a0_s = {s.a0_s[0], control_select_n};
        next_s.a1_s = {s.a1_s[0], control_serial_in};
        next_s.done_s = {s.done_s[0], spi_done};
        next_s.done_prev = s.done_s[1];
        {next_s.scl_f, next_s.scl_cnt} = scl_step;
        {next_s.sda_f, next_s.sda_cnt} = sda_step;
        next_s.scl_prev = s.scl_f;
        next_s.sda_prev = s.sda_f;

        // 4-wire write commit: the word holds only until select rises and clears
        // its index and rw bit, which must come later than the three-cycle crossing
        if (s.done_s[1] && !s.done_prev && !s.sel_s[1]) begin
            if (!spi_word.rw && dscp_writable(spi_word.idx)) begin
                next_s.regs[spi_word.idx[3:0]] = spi_word.data;
            end
        end

        if (!s.sel_s[1]) begin
            next_s.st = I2C_IDLE;
            next_s.oe = 1'b0;
        end else if (bus_start) begin
            next_s.st = I2C_ADDR;
            next_s.bitn = 4'h0;
            next_s.oe = 1'b0;
        end else if (bus_stop) begin
            next_s.st = I2C_IDLE;
            next_s.oe = 1'b0;
        end else begin
            case (s.st)
                I2C_ADDR, I2C_INDEX, I2C_WDATA: begin
                    if (scl_rise) begin
                        next_s.sh = {s.sh[6:0], s.sda_f};
                        next_s.bitn = s.bitn + 4'h1;
                    end else if (scl_fall && s.bitn == BYTE_BITS) begin
                        next_s.bitn = 4'h0;
                        next_s.st = I2C_WAIT;
                        if (s.st == I2C_ADDR) begin
                            if (s.sh[7:1] == {SLAVE_ADDR_HI, s.a1_s[1],
                                              s.a0_s[1]}) begin
                                next_s.rw = s.sh[0];
                                next_s.oe = 1'b1;
                                next_s.st = I2C_AACK;
                            end
                        end else if (s.st == I2C_INDEX) begin
                            next_s.idx = s.sh[6:0];
                            next_s.wrote = 1'b0;
                            if (dscp_readable(s.sh[6:0])) begin
                                next_s.oe = 1'b1;
                                next_s.st = I2C_IACK;
                            end
                        end else begin
                            if (dscp_writable(s.idx)) begin
                                next_s.regs[s.idx[3:0]] = s.sh;
                                next_s.last_wr = s.idx;
                                next_s.wrote = 1'b1;
                                next_s.idx = s.idx + 7'h01;
                                next_s.oe = 1'b1;
                                next_s.st = I2C_WACK;
                            end
                        end
                    end
                end
                I2C_AACK: begin
                    if (scl_fall) begin
                        next_s.bitn = 4'h0;
                        if (s.rw) begin
                            next_s.idx = ridx;
                            next_s.wrote = 1'b0;
                            next_s.sh = dscp_rd_lookup(s.regs, ridx);
                            next_s.oe = !next_s.sh[7];
                            next_s.st = I2C_RDATA;
                        end else begin
                            next_s.oe = 1'b0;
                            next_s.st = I2C_INDEX;
                        end
                    end
                end
                I2C_IACK, I2C_WACK: begin
                    if (scl_fall) begin
                        next_s.oe = 1'b0;
                        next_s.st = I2C_WDATA;
                    end
                end
                I2C_RDATA: begin
                    if (scl_rise) begin
                        next_s.bitn = s.bitn + 4'h1;
                    end else if (scl_fall) begin
                        if (s.bitn == BYTE_BITS) begin
                            next_s.oe = 1'b0;
                            next_s.idx = s.idx + 7'h01;
                            next_s.st = I2C_RACK;
                        end else begin
                            next_s.sh = {s.sh[6:0], 1'b0};
                            next_s.oe = !s.sh[6];
                        end
                    end
                end
                I2C_RACK: begin
                    if (scl_rise) begin
                        next_s.nack = s.sda_f;
                    end else if (scl_fall) begin
                        if (!s.nack) begin
                            next_s.bitn = 4'h0;
                            next_s.sh = rbyte;
                            next_s.oe = !rbyte[7];
                            next_s.st = I2C_RDATA;
                        end else begin
                            next_s.st = I2C_WAIT;
                        end
                    end
                end
                I2C_IDLE, I2C_WAIT: begin
                    next_s.oe = 1'b0;
                end
                default: begin
                    next_s.st = I2C_IDLE;
                    next_s.oe = 1'b0;
                end
            endcase
        end
    end

    // -----------------------------------------------------------------
    // registers
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
            s.scl_s <= 2'h3;
            s.sda_s <= 2'h3;
            s.scl_f <= 1'b1;
            s.sda_f <= 1'b1;
            s.scl_prev <= 1'b1;
            s.sda_prev <= 1'b1;
            s.st <= I2C_IDLE;
            s.regs <= {REG_COUNT{REG_RESET}};
        end else begin
            s <= next_s;
        end
    end

    assign sda_oe = s.oe;
    assign mode_regs = s.regs;

endmodule

// ### common/dscp_pkg.sv
// shared constants and types of the dual serial control port
// assumes a 250 MHz system clock and a 16-bit control word on the 4-wire port
package dscp_pkg;

    // -----------------------------------------------------------------
    // timing
    // -----------------------------------------------------------------
    localparam int SYS_PERIOD_PS = 4000;
    localparam int SPIKE_NS = 50;
    localparam int SPIKE_CYC = (SPIKE_NS * 1000 + SYS_PERIOD_PS - 1)
                               / SYS_PERIOD_PS;
    localparam logic [3:0] SPIKE_CNT = 4'(SPIKE_CYC);

    // -----------------------------------------------------------------
    // control word layout
    // -----------------------------------------------------------------
    localparam int WORD_BITS = 16;
    localparam int RW_BIT = 15;
    localparam int IDX_MSB = 14;
    localparam int IDX_LSB = 8;
    localparam logic [3:0] SPI_LAST_CNT = 4'hF;
    localparam logic [3:0] SPI_HALF_CNT = 4'h7;

    // -----------------------------------------------------------------
    // addressing and register map
    // -----------------------------------------------------------------
    localparam logic [4:0] SLAVE_ADDR_HI = 5'h13;
    localparam logic [6:0] IDX_RD_FIRST = 7'h10;
    localparam logic [6:0] IDX_RD_LAST = 7'h1F;
    localparam logic [6:0] IDX_WR_FIRST = 7'h10;
    localparam logic [6:0] IDX_WR_LAST = 7'h17;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] REG_UNDEF = 8'h00;
    localparam int REG_COUNT = 16;
    localparam logic [3:0] BYTE_BITS = 4'h8;

    typedef logic [REG_COUNT-1:0][7:0] dscp_regs_t;

    typedef struct packed {
        logic rw;
        logic [6:0] idx;
        logic [7:0] data;
    } dscp_word_t;

    typedef enum logic [9:0] {
        I2C_IDLE  = 10'h001,
        I2C_ADDR  = 10'h002,
        I2C_AACK  = 10'h004,
        I2C_INDEX = 10'h008,
        I2C_IACK  = 10'h010,
        I2C_WDATA = 10'h020,
        I2C_WACK  = 10'h040,
        I2C_RDATA = 10'h080,
        I2C_RACK  = 10'h100,
        I2C_WAIT  = 10'h200
    } dscp_i2c_state_t;

    // read value for an index; undefined indices in the window give a byte
    function automatic logic [7:0] dscp_rd_lookup(dscp_regs_t regs,
                                                  logic [6:0] idx);
        if (idx >= IDX_RD_FIRST && idx <= IDX_RD_LAST) begin
            return regs[idx[3:0]];
        end
        return REG_UNDEF;
    endfunction

    function automatic logic dscp_writable(logic [6:0] idx);
        return idx >= IDX_WR_FIRST && idx <= IDX_WR_LAST;
    endfunction

    function automatic logic dscp_readable(logic [6:0] idx);
        return idx >= IDX_RD_FIRST && idx <= IDX_RD_LAST;
    endfunction

endpackage

// ### verilog/dscp_spi_port.sv
// 4-wire control port shifter, running only on the control bit clock
// assumes the register array presented on regs is quasi-static
`timescale 1ns/10ps
module dscp_spi_port (
    input wire logic control_bit_clock,
    input wire logic control_select_n,
    input wire logic control_serial_in,
    input wire logic interface_select_pin,
    input wire dscp_pkg::dscp_regs_t regs,
    output logic word_done,
    output dscp_pkg::dscp_word_t word,
    output logic serial_out,
    output logic serial_out_oe
);
    import dscp_pkg::*;

    // -----------------------------------------------------------------
    // rising-edge side: input shift
    // -----------------------------------------------------------------
    typedef struct packed {
        logic [3:0] cnt;
        logic done;
        logic rw;
        logic [6:0] idx;
    } dscp_spi_rise_t;

    typedef struct packed {
        logic sel_s1;
        logic sel_s2;
        logic dout;
        logic oe;
    } dscp_spi_fall_t;

    dscp_spi_rise_t r;
    dscp_spi_rise_t next_r;
    dscp_spi_fall_t f;
    dscp_spi_fall_t next_f;
    logic [15:0] shreg;
    logic [7:0] rd_byte;

    // the word register has no clear: it is read only at the eighth rise, for seven
    // bits of the frame, and once done is set, when all sixteen have been shifted in
    always_ff @(posedge control_bit_clock) begin
        shreg <= {shreg[14:0], control_serial_in};
    end

    always_comb begin
        next_r = r;
        if (!r.done) begin
            next_r.cnt = r.cnt + 4'h1;
            if (r.cnt == SPI_HALF_CNT) begin
                // the eighth bit is taken straight from the pin at its rise
                next_r.idx = {shreg[5:0], control_serial_in};
                next_r.rw = shreg[6];
            end
            if (r.cnt == SPI_LAST_CNT) begin
                next_r.done = 1'b1;
            end
        end
    end

    // select high clears the transaction, so each word needs its own frame
    always_ff @(posedge control_bit_clock or posedge control_select_n) begin
        if (control_select_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // -----------------------------------------------------------------
    // falling-edge side: readback
    // -----------------------------------------------------------------
    assign rd_byte = dscp_rd_lookup(regs, r.idx);

    always_comb begin
        next_f = f;
        next_f.sel_s1 = interface_select_pin;
        next_f.sel_s2 = f.sel_s1;
        next_f.oe = 1'b0;
        next_f.dout = 1'b0;
        // drive only in 4-wire mode, after the eighth clock of a read
        if (!f.sel_s2 && r.rw && r.cnt[3] && !r.done) begin
            next_f.oe = 1'b1;
            next_f.dout = rd_byte[~r.cnt[2:0]];
        end
    end

    always_ff @(negedge control_bit_clock or posedge control_select_n) begin
        if (control_select_n) begin
            f <= 4'hC;
        end else begin
            f <= next_f;
        end
    end

    assign word_done = r.done;
    assign word = {r.rw, r.idx, shreg[7:0]};
    assign serial_out = f.dout;
    assign serial_out_oe = f.oe;

endmodule

// ### test/dscp_checker.sv
// checker: concurrent properties on the control port pins
// assumes binding to dscp_top; the 4-wire helper runs on the bit clock
`timescale 1ns/10ps
module dscp_checker (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic interface_select_pin,
    input wire logic control_select_n,
    input wire logic control_serial_in,
    input wire logic control_bit_clock,
    input wire logic control_serial_out_in,
    input wire logic control_serial_out,
    input wire logic control_serial_out_oe,
    input wire logic sda_oe,
    input wire dscp_pkg::dscp_regs_t mode_regs
);
    import dscp_pkg::*;
    // ------------------------------------------------------------
    // 4-wire frame tracking
    // ------------------------------------------------------------
    logic [4:0] bit_cnt;
    logic rd_req;
    logic [6:0] rd_idx;
    logic [7:0] rd_byte;
    // select high clears, mirroring the port's own async clear
    always_ff @(posedge control_bit_clock or posedge control_select_n) begin
        if (control_select_n) begin
            bit_cnt <= 5'h00;
            rd_req <= 1'b0;
            rd_idx <= 7'h00;
        end else begin
            if (bit_cnt == 5'h00) begin
                rd_req <= control_serial_in;
            end
            if (bit_cnt != 5'h00 && bit_cnt < 5'h08) begin
                rd_idx <= {rd_idx[5:0], control_serial_in};
            end
            if (bit_cnt != 5'h10) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end
    assign rd_byte = (rd_idx >= 7'h10 && rd_idx <= 7'h1F)
                     ? mode_regs[rd_idx[3:0]] : 8'h00;
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    sequence s_read_phase;
        !interface_select_pin && rd_req && bit_cnt >= 5'h08
        && bit_cnt < 5'h10;
    endsequence
    sequence s_ack_hold;
        sda_oe [*8];
    endsequence
    a_spi_read_bits: assert property (@(posedge control_bit_clock)
        disable iff (control_select_n) s_read_phase |-> control_serial_out_oe
        && control_serial_out == rd_byte[3'(5'h0F - bit_cnt)])
        else $error("4-wire read bit wrong");
    a_spi_oe_early: assert property (@(posedge control_bit_clock)
        disable iff (control_select_n)
        !interface_select_pin && bit_cnt < 5'h08 |-> !control_serial_out_oe)
        else $error("4-wire output enabled too early");
    a_spi_oe_write: assert property (@(posedge control_bit_clock)
        disable iff (control_select_n) !interface_select_pin && !rd_req
        && bit_cnt != 5'h00 |-> !control_serial_out_oe)
        else $error("4-wire output enabled in a write");
    a_oe_needs_select: assert property (@(posedge clk_sys)
        disable iff (rst) control_select_n && $past(control_select_n)
        |-> !control_serial_out_oe) else $error("output kept without select");
    a_sda_quiet_spi: assert property (@(posedge clk_sys)
        disable iff (rst) !interface_select_pin
        && !$past(interface_select_pin, 4) |-> !sda_oe)
        else $error("data line pulled in 4-wire mode");
    a_oe_quiet_i2c: assert property (@(posedge clk_sys)
        disable iff (rst) interface_select_pin
        && $past(interface_select_pin, 2) |-> !control_serial_out_oe)
        else $error("4-wire output driven in two-wire mode");
    a_regs_need_ack: assert property (@(posedge clk_sys)
        disable iff (rst) interface_select_pin && $changed(mode_regs)
        && $past(interface_select_pin, 4) |-> ##[0:2] sda_oe)
        else $error("register changed without acknowledge");
    a_ack_stands: assert property (@(posedge clk_sys)
        disable iff (rst) $rose(sda_oe) |-> s_ack_hold)
        else $error("data line pull too short");
    a_sda_scl_low: assert property (@(posedge clk_sys)
        disable iff (rst) interface_select_pin && $changed(sda_oe)
        |-> !control_bit_clock) else $error("data line moved with clock high");
endmodule
bind dscp_top dscp_checker chk_u (
    .clk_sys, .rst, .interface_select_pin, .control_select_n,
    .control_serial_in, .control_bit_clock, .control_serial_out_in,
    .control_serial_out, .control_serial_out_oe, .sda_oe, .mode_regs
);

// ### test/dscp_host_model.sv
// host model: drives the control pins as 4-wire master or bus master
// assumes the bench resolves the shared data pin and returns its level
`timescale 1ns/10ps
module dscp_host_model (
    input wire logic clk_sys,
    input wire logic pin,
    output logic sel_n,
    output logic sdi,
    output logic bclk,
    output logic sda_low
);
    // half bit of 40 cycles keeps well clear of the 13-cycle filter
    localparam int HALF = 40;
    // select rises at 1 ns so the async clear sees a real edge
    // instead of racing the time-zero start of the port's processes
    initial begin
        sel_n = 1'b0;
        sdi = 1'b0;
        bclk = 1'b0;
        sda_low = 1'b0;
        #1 sel_n = 1'b1;
    end
    task automatic hw(input int n);
        repeat (n) @(negedge clk_sys);
    endtask
    // 16 bits, shifted out before each rise, read back at rises
    task automatic spi_word(input logic [15:0] w, output logic [7:0] rd);
        hw(1);
        sel_n = 1'b0;
        #5;
        for (int i = 15; i >= 0; i--) begin
            sdi = w[i];
            #3 bclk = 1'b1;
            if (i < 8) begin
                rd[i] = pin;
            end
            #3 bclk = 1'b0;
        end
        #15 sel_n = 1'b1;
        sdi = ~sdi;
        hw(25);
    endtask
    // device select levels live on the reused pins
    task automatic set_adr(input logic [1:0] a);
        sel_n = a[0];
        sdi = a[1];
        bclk = 1'b1;
        sda_low = 1'b0;
        hw(HALF);
    endtask
    task automatic bit_x(input logic low, output logic smp);
        sda_low = low;
        hw(HALF);
        bclk = 1'b1;
        hw(HALF);
        smp = pin;
        bclk = 1'b0;
        hw(HALF);
    endtask
    // start or repeated start, then stop, all made by the master
    task automatic i2c_start();
        sda_low = 1'b0;
        hw(HALF);
        bclk = 1'b1;
        hw(HALF);
        sda_low = 1'b1;
        hw(HALF);
        bclk = 1'b0;
        hw(HALF);
    endtask
    task automatic i2c_stop();
        sda_low = 1'b1;
        hw(HALF);
        bclk = 1'b1;
        hw(HALF);
        sda_low = 1'b0;
        hw(HALF);
    endtask
    task automatic i2c_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(!b[i], s);
        end
        bit_x(1'b0, ack);
    endtask
    task automatic i2c_read(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_x(1'b0, b[i]);
        end
        bit_x(!last, s);
    endtask
endmodule

// ### test/dscp_top_tb_top.sv
// testbench for the dual serial control port, host model on the pins
// assumes pull-up on the shared data pin; checker is bound separately
`timescale 1ns/10ps
module dscp_top_tb_top;
    import dscp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic isel = 1'b0;
    logic sel_n, sdi, bclk, sda_low, so, so_oe, sda_oe, pin;
    dscp_regs_t mode_regs;
    logic [7:0] exp_regs [16];
    logic [8:0] note_q [$];
    logic [8:0] got;
    event got_ev;
    int err_total = 0;
    int cmp_count = 0;
    logic [31:0] seed = 32'hAF70E2C3;
    assign pin = so_oe ? so : !(sda_oe || sda_low);
    initial begin
        forever #2 clk_sys = ~clk_sys;
    end
    dscp_top dut_u (.clk_sys(clk_sys), .rst(rst),
        .interface_select_pin(isel), .control_select_n(sel_n),
        .control_serial_in(sdi), .control_bit_clock(bclk),
        .control_serial_out_in(pin), .control_serial_out(so),
        .control_serial_out_oe(so_oe), .sda_oe(sda_oe),
        .mode_regs(mode_regs));
    dscp_host_model host_u (.clk_sys(clk_sys), .pin(pin), .sel_n(sel_n),
        .sdi(sdi), .bclk(bclk), .sda_low(sda_low));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic print_verdict();
        $display("compares %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // driver notes the expectation, the monitor compares on the result
    task automatic chk(input logic [8:0] e, input logic [8:0] g);
        note_q.push_back(e);
        got = g;
        -> got_ev;
        #1;
    endtask
    always @(got_ev) begin
        cmp_count++;
        if (note_q.size() == 0 || got !== note_q[0]) begin
            err_total++;
            $display("[ERR] %0t result %h not as noted", $time, got);
        end
        if (note_q.size() != 0) begin
            void'(note_q.pop_front());
        end
    end
    task automatic i2c_wr(input logic [7:0] b, input logic nak);
        logic a;
        host_u.i2c_byte(b, a);
        chk({8'h00, nak}, {8'h00, a});
    endtask
    task automatic i2c_rd(input logic last, input logic [7:0] e);
        logic [7:0] b;
        host_u.i2c_read(last, b);
        chk({1'b0, e}, {1'b0, b});
    endtask
    initial begin
        repeat (90000) @(posedge clk_sys);
        err_total++;
        $display("[ERR] %0t run did not finish", $time);
        print_verdict();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [7:0] r;
        logic [6:0] odd [3];
        odd = '{7'h0F, 7'h1F, 7'h20};
        repeat (4) @(negedge clk_sys);
        rst = 1'b0;
        repeat (8) @(negedge clk_sys);
        for (int i = 0; i < 9; i++) begin
            seed = lfsr(seed);
            d = seed[7:0];
            host_u.spi_word({1'b0, 7'h10 + 7'(i), d}, r);
            exp_regs[i] = (i < 8) ? d : 8'h00;
            repeat (8) @(negedge clk_sys);
            chk({1'b0, exp_regs[i]}, {1'b0, mode_regs[i]});
            host_u.spi_word({1'b1, 7'h10 + 7'(i), 8'h00}, r);
            chk({1'b0, exp_regs[i]}, {1'b0, r});
        end
        for (int i = 9; i < 16; i++) begin
            exp_regs[i] = 8'h00;
        end
        foreach (odd[k]) begin
            host_u.spi_word({1'b1, odd[k], 8'h00}, r);
            chk(9'h000, {1'b0, r});
        end
        $display("4-wire test done");
        isel = 1'b1;
        repeat (8) @(negedge clk_sys);
        host_u.spi_word({1'b0, 7'h10, ~exp_regs[0]}, r);
        repeat (8) @(negedge clk_sys);
        chk({1'b0, exp_regs[0]}, {1'b0, mode_regs[0]});
        host_u.set_adr(2'b10);
        for (int i = 0; i < 5; i++) begin
            host_u.i2c_start();
            d = (i < 4) ? {5'h13, 2'(i), 1'b0} : 8'h94;
            i2c_wr(d, i != 2);
            host_u.i2c_stop();
        end
        $display("address test done");
        host_u.i2c_start();
        i2c_wr(8'h9C, 1'b0);
        i2c_wr(8'h16, 1'b0);
        for (int i = 6; i < 9; i++) begin
            seed = lfsr(seed);
            if (i < 8) begin
                exp_regs[i] = seed[7:0];
            end
            i2c_wr(seed[7:0], i == 8);
        end
        host_u.i2c_stop();
        chk({1'b0, exp_regs[6]}, {1'b0, mode_regs[6]});
        chk({1'b0, exp_regs[7]}, {1'b0, mode_regs[7]});
        host_u.i2c_start();
        i2c_wr(8'h9C, 1'b0);
        i2c_wr(8'h05, 1'b1);
        host_u.i2c_stop();
        $display("write test done");
        seed = lfsr(seed);
        exp_regs[5] = seed[7:0];
        host_u.i2c_start();
        i2c_wr(8'h9C, 1'b0);
        i2c_wr(8'h15, 1'b0);
        i2c_wr(exp_regs[5], 1'b0);
        host_u.i2c_start();
        i2c_wr(8'h9D, 1'b0);
        i2c_rd(1'b0, exp_regs[5]);
        i2c_rd(1'b1, exp_regs[6]);
        host_u.i2c_stop();
        host_u.i2c_start();
        i2c_wr(8'h9C, 1'b0);
        i2c_wr(8'h1F, 1'b0);
        host_u.i2c_start();
        i2c_wr(8'h9D, 1'b0);
        i2c_rd(1'b0, exp_regs[15]);
        i2c_rd(1'b1, 8'h00);
        host_u.i2c_stop();
        $display("read test done");
        print_verdict();
    end
endmodule
